//--- core/column_driver_load_sequencer.sv
// Pixel word capture, channel sequencing and two-stage latches of a six-channel column driver
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ps
// How it works
// - One 10-bit word per loading edge, shared bus
// - Two-stage latches so outputs change together
// - Sequence starts first rising edge after start
// - Transfer copies first stage on falling edge
// - Direction low ascends, high descends channels
// - Single device: words 0..5 into channels 0..5
// - Edge select high rising, low falling capture
// - Paired devices interleave even and odd words
// - Start and transfer high: direct load, falling
// - Address on rising edge, data next falling
// - Standby high clears all latched data
module column_driver_load_sequencer #(
    parameter int FIFO_DEPTH = col_drv_pkg::FIFO_DEPTH
) (
    input  wire logic                               pclk,
    input  wire logic                               presetn,
    input  wire logic                               psel,
    input  wire logic                               penable,
    input  wire logic                               pwrite,
    input  wire logic [col_drv_pkg::APB_AW-1:0]     paddr,
    input  wire logic [31:0]                        pwdata,
    output logic      [31:0]                        prdata,
    output logic                                    pready,
    output logic                                    pslverr,
    input  wire logic                               pixel_clock,
    input  wire logic [col_drv_pkg::WORD_W-1:0]     pixel_data,
    input  wire logic                               sequence_start,
    input  wire logic                               transfer_strobe,
    input  wire logic                               standby_input,
    input  wire logic                               edge_select,
    input  wire logic                               load_direction,
    input  wire logic [col_drv_pkg::CH_W-1:0]       channel_address,
    output logic      [col_drv_pkg::WORD_W-1:0]     column_output_0,
    output logic      [col_drv_pkg::WORD_W-1:0]     column_output_1,
    output logic      [col_drv_pkg::WORD_W-1:0]     column_output_2,
    output logic      [col_drv_pkg::WORD_W-1:0]     column_output_3,
    output logic      [col_drv_pkg::WORD_W-1:0]     column_output_4,
    output logic      [col_drv_pkg::WORD_W-1:0]     column_output_5
);
    localparam int SYNC_W = 9 + col_drv_pkg::WORD_W + col_drv_pkg::CH_W;
    localparam int LVL_W  = $clog2(FIFO_DEPTH + 1);

    typedef logic [col_drv_pkg::NUM_CH-1:0][col_drv_pkg::WORD_W-1:0] bank_t;

    typedef struct packed {
        logic                             clk_prev;
        logic                             seq_prev;
        logic                             xfr_prev;
        logic                             armed;
        logic                             started;
        logic [col_drv_pkg::CH_W-1:0]     count;
        logic [col_drv_pkg::CH_W-1:0]     addr_q;
        logic                             addr_mode_q;
        logic                             direct_q;
        logic                             xfr_pend;
        logic                             fall_q;
        bank_t                            first;
        bank_t                            out;
        logic                             hold;
        logic                             ovf;
        logic [31:0]                      rdata;
        logic                             err;
    } state_s;

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [2:0] chan_of(input logic [2:0] step, input logic dir);
        chan_of = dir ? 3'(col_drv_pkg::LAST_STEP - step) : step;
    endfunction

    function automatic logic reg_hit(input logic [7:0] a);
        reg_hit = (a[1:0] == 2'h0) &&
                  ((a == col_drv_pkg::CTRL_OFS) || (a == col_drv_pkg::STATUS_OFS) ||
                   ((a >= col_drv_pkg::CH_OFS) && (a < col_drv_pkg::CH_END)));
    endfunction

    // ************************************************************
    // Pin synchronisation
    // ************************************************************
    logic [SYNC_W-1:0]                  sync_q;
    logic                               clk_s;
    logic                               seq_s;
    logic                               xfr_s;
    logic                               standby_input_s;
    logic                               edge_s;
    logic                               dir_s;
    logic                               spare_s;
    logic                               spare2_s;
    logic                               spare3_s;
    logic [col_drv_pkg::WORD_W-1:0]     data_s;
    logic [col_drv_pkg::CH_W-1:0]       addr_s;

    // Data and clock share delay, so data is aligned with the seen edge
    pin_sync #(
        .WIDTH (SYNC_W)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({pixel_clock, sequence_start, transfer_strobe, standby_input, edge_select,
                   load_direction, 3'h0, pixel_data, channel_address}),
        .q       (sync_q)
    );

    assign {clk_s, seq_s, xfr_s, standby_input_s, edge_s, dir_s, spare_s, spare2_s, spare3_s, data_s, addr_s} = sync_q;

    // ************************************************************
    // Word buffer
    // ************************************************************
    logic                               push_valid;
    logic [col_drv_pkg::ENTRY_W-1:0]    push_data;
    logic                               fifo_in_ready;
    logic                               fifo_out_valid;
    logic                               pop;
    logic [col_drv_pkg::ENTRY_W-1:0]    fifo_out;
    logic [LVL_W-1:0]                   fifo_level;

    word_fifo #(
        .WIDTH (col_drv_pkg::ENTRY_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .flush     (standby_input_s),
        .in_valid  (push_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (push_data),
        .out_valid (fifo_out_valid),
        .out_ready (pop),
        .out_data  (fifo_out),
        .level     (fifo_level)
    );

    // ************************************************************
    // Capture, drain and register logic
    // ************************************************************
    state_s                             st;
    state_s                             next_st;
    logic                               rise;
    logic                               fall;
    logic                               seq_new;
    logic                               seq_push;
    logic                               apply_xfr;
    logic                               apply_both;
    logic [1:0]                         pop_kind;
    logic [2:0]                         pop_ch;
    logic [7:0]                         ch_ofs;

    assign rise     = clk_s & ~st.clk_prev;
    assign fall     = ~clk_s & st.clk_prev;
    assign seq_new  = seq_s & ~st.seq_prev & (addr_s == col_drv_pkg::SEQ_ADDR);
    assign pop_kind = fifo_out[col_drv_pkg::KIND_LSB +: col_drv_pkg::KIND_W];
    assign pop_ch   = fifo_out[col_drv_pkg::CH_LSB +: col_drv_pkg::CH_W];
    assign ch_ofs   = paddr - col_drv_pkg::CH_OFS;

    always_comb begin
        next_st          = st;
        push_valid       = 1'b0;
        push_data        = '0;
        seq_push         = 1'b0;
        apply_xfr        = 1'b0;
        apply_both       = 1'b0;
        pop              = fifo_out_valid & ~st.hold;
        next_st.clk_prev = clk_s;
        next_st.seq_prev = seq_s;
        next_st.xfr_prev = xfr_s;
        next_st.fall_q   = fall;
        if (xfr_s && !st.xfr_prev) begin
            next_st.xfr_pend = 1'b1;
        end
        // arm on start, begin at next rising edge
        if (seq_new) begin
            next_st.armed   = 1'b1;
            next_st.started = 1'b0;
            next_st.count   = '0;
        end else if (st.armed) begin
            // edge select picks the capturing edge
            // both edges carry words in paired use
            if (rise) begin
                next_st.started = 1'b1;
                seq_push        = edge_s;
            end else if (fall && st.started && !edge_s) begin
                seq_push = 1'b1;
            end
        end
        // one word from the shared bus per edge
        if (seq_push) begin
            push_valid    = 1'b1;
            // direction sets order: channel is step when low, five minus step when high
            push_data     = {col_drv_pkg::KIND_FIRST, chan_of(st.count, dir_s), data_s};
            next_st.count = 3'(st.count + 3'h1);
            if (st.count == col_drv_pkg::LAST_STEP) begin
                next_st.armed = 1'b0;
            end
        end else if (fall && st.addr_mode_q && !st.armed) begin
            // address from rising edge, data on falling
            // static start and transfer load both stages
            push_valid = 1'b1;
            push_data  = {st.direct_q ? col_drv_pkg::KIND_BOTH : col_drv_pkg::KIND_FIRST, st.addr_q, data_s};
        end else if (st.fall_q && st.xfr_pend) begin
            // transfer acts at the falling edge after it
            push_valid = 1'b1;
            push_data  = {col_drv_pkg::KIND_XFR, {(col_drv_pkg::CH_W + col_drv_pkg::WORD_W){1'b0}}};
            if (fifo_in_ready) begin
                next_st.xfr_pend = xfr_s & ~st.xfr_prev;
            end
        end
        if (rise) begin
            next_st.addr_q      = addr_s;
            next_st.addr_mode_q = seq_s & (addr_s != col_drv_pkg::SEQ_ADDR);
            next_st.direct_q    = seq_s & xfr_s & (addr_s != col_drv_pkg::SEQ_ADDR);
        end
        // Drain: words land in the first stage, outputs move on transfer or direct load
        if (pop) begin
            // transfer changes the whole bank, direct load one channel
            unique case (pop_kind)
                col_drv_pkg::KIND_XFR: begin
                    next_st.out = st.first;
                    apply_xfr   = 1'b1;
                end
                col_drv_pkg::KIND_BOTH: begin
                    if (pop_ch < col_drv_pkg::CH_COUNT) begin
                        next_st.first[pop_ch] = fifo_out[col_drv_pkg::WORD_W-1:0];
                        next_st.out[pop_ch]   = fifo_out[col_drv_pkg::WORD_W-1:0];
                        apply_both            = 1'b1;
                    end
                end
                default: begin
                    if (pop_ch < col_drv_pkg::CH_COUNT) begin
                        next_st.first[pop_ch] = fifo_out[col_drv_pkg::WORD_W-1:0];
                    end
                end
            endcase
        end
        // APB: read data and error latched in setup, write at access
        if (psel && !penable) begin
            next_st.err   = ~reg_hit(paddr);
            next_st.rdata = '0;
            if (paddr == col_drv_pkg::CTRL_OFS) begin
                next_st.rdata[col_drv_pkg::HOLD_BIT] = st.hold;
            end else if (paddr == col_drv_pkg::STATUS_OFS) begin
                next_st.rdata[col_drv_pkg::ST_ARMED]                  = st.armed;
                next_st.rdata[col_drv_pkg::ST_COUNT +: col_drv_pkg::CH_W] = st.count;
                next_st.rdata[col_drv_pkg::ST_OVF]                    = st.ovf;
                next_st.rdata[col_drv_pkg::ST_EMPTY]                  = ~fifo_out_valid;
                next_st.rdata[col_drv_pkg::ST_FULL]                   = ~fifo_in_ready;
                next_st.rdata[col_drv_pkg::ST_STANDBY_INPUT]                   = standby_input_s;
                next_st.rdata[col_drv_pkg::ST_LEVEL +: LVL_W]         = fifo_level;
            end else if (reg_hit(paddr)) begin
                next_st.rdata[col_drv_pkg::WORD_W-1:0] = st.out[ch_ofs[4:2]];
            end
        end
        if (psel && penable && pwrite && !st.err) begin
            if (paddr == col_drv_pkg::CTRL_OFS) begin
                next_st.hold = pwdata[col_drv_pkg::HOLD_BIT];
            end else if (paddr == col_drv_pkg::STATUS_OFS && pwdata[col_drv_pkg::ST_OVF]) begin
                next_st.ovf = 1'b0;
            end
        end
        // Lost word wins over a clear in the same cycle
        if (push_valid && !fifo_in_ready) begin
            next_st.ovf = 1'b1;
        end
        // standby discards all latched data and sequence state
        if (standby_input_s) begin
            next_st.armed       = 1'b0;
            next_st.started     = 1'b0;
            next_st.count       = '0;
            next_st.addr_mode_q = 1'b0;
            next_st.direct_q    = 1'b0;
            next_st.xfr_pend    = 1'b0;
            next_st.first       = '0;
            next_st.out         = '0;
            push_valid          = 1'b0;
            pop                 = 1'b0;
            apply_xfr           = 1'b0;
            apply_both          = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign pready          = psel & penable;
    assign pslverr         = psel & penable & st.err;
    assign prdata          = st.rdata;
    assign column_output_0 = st.out[0];
    assign column_output_1 = st.out[1];
    assign column_output_2 = st.out[2];
    assign column_output_3 = st.out[3];
    assign column_output_4 = st.out[4];
    assign column_output_5 = st.out[5];

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    stop_after_six_a: assert property (seq_push && st.count == col_drv_pkg::LAST_STEP |=> !st.armed)
        else $error("sequencer still armed after sixth word");
    bank_change_a: assert property (st.out != $past(st.out) |-> $past(apply_xfr || apply_both || standby_input_s))
        else $error("outputs changed without transfer");
    xfr_copy_a: assert property (apply_xfr |=> st.out == $past(st.first))
        else $error("transfer did not copy first stage");
    standby_clear_a: assert property (standby_input_s |=> st.out == '0 && st.first == '0 && !st.armed)
        else $error("standby did not clear state");
    edge_pick_a: assert property (seq_push |-> (edge_s ? rise : fall))
        else $error("word captured on wrong edge");
    start_rise_a: assert property (seq_push && st.count == '0 && edge_s |-> rise && !st.started)
        else $error("sequence did not begin on first rising edge");
    seq_chan_a: assert property (seq_push && !standby_input_s |-> push_data[col_drv_pkg::CH_LSB +: col_drv_pkg::CH_W]
                                 == (dir_s ? 3'(col_drv_pkg::LAST_STEP - st.count) : st.count))
        else $error("sequence channel out of order");
    odd_after_even_a: assert property (seq_push && !edge_s |-> st.started)
        else $error("odd word taken before even edge");
    addr_load_a: assert property (fall && st.addr_mode_q && !st.armed && !standby_input_s |->
                                  push_valid && push_data[col_drv_pkg::CH_LSB +: col_drv_pkg::CH_W] == st.addr_q)
        else $error("addressed word not pushed to latched channel");
    direct_both_a: assert property (apply_both |=> st.out[$past(pop_ch)] == st.first[$past(pop_ch)])
        else $error("direct load missed output stage");

    full_seq_c: cover property (seq_push && st.count == col_drv_pkg::LAST_STEP);
    xfr_c: cover property (apply_xfr);
    direct_c: cover property (apply_both);
    ovf_c: cover property (push_valid && !fifo_in_ready);
endmodule

//--- core/col_drv_pkg.sv
// Shared constants for the six-channel column driver load sequencer
package col_drv_pkg;
    // ************************************************************
    // Word and channel shape
    // ************************************************************
    localparam int         WORD_W     = 10;
    localparam int         NUM_CH     = 6;
    localparam int         CH_W       = 3;
    localparam logic [2:0] CH_COUNT   = 3'h6;
    localparam logic [2:0] SEQ_ADDR   = 3'h7;
    localparam logic [2:0] LAST_STEP  = 3'h5;
    localparam int         FIFO_DEPTH = 32;

    // ************************************************************
    // Buffer entry layout: kind, channel, data word
    // ************************************************************
    localparam int         KIND_W     = 2;
    localparam int         CH_LSB     = WORD_W;
    localparam int         KIND_LSB   = WORD_W + CH_W;
    localparam int         ENTRY_W    = KIND_W + CH_W + WORD_W;
    localparam logic [1:0] KIND_FIRST = 2'h0;
    localparam logic [1:0] KIND_BOTH  = 2'h1;
    localparam logic [1:0] KIND_XFR   = 2'h2;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam int         APB_AW     = 8;
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] CH_OFS     = 8'h08;
    localparam logic [7:0] CH_END     = 8'h20;
    localparam int         HOLD_BIT   = 0;
    localparam int         ST_ARMED   = 0;
    localparam int         ST_COUNT   = 1;
    localparam int         ST_OVF     = 4;
    localparam int         ST_EMPTY   = 5;
    localparam int         ST_FULL    = 6;
    localparam int         ST_STANDBY_INPUT    = 7;
    localparam int         ST_LEVEL   = 8;
endpackage

//--- core/pin_sync.sv
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } state_s;

    state_s st;
    state_s next_st;

    // First stage feeds only the second
    always_comb begin
        next_st    = st;
        next_st.s1 = d;
        next_st.s2 = st.s1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign q = st.s2;
endmodule

//--- core/word_fifo.sv
// Synchronous FIFO with valid/ready on both sides and a flush
`timescale 1ns/1ps
module word_fifo #(
    parameter int WIDTH = 15,
    parameter int DEPTH = 32
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       flush,
    input  wire logic                       in_valid,
    output logic                            in_ready,
    input  wire logic [WIDTH-1:0]           in_data,
    output logic                            out_valid,
    input  wire logic                       out_ready,
    output logic      [WIDTH-1:0]           out_data,
    output logic      [$clog2(DEPTH+1)-1:0] level
);
    // DEPTH must be a power of two; pointers carry one wrap bit
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0]                 wr;
        logic [AW:0]                 rd;
    } state_s;

    state_s      st;
    state_s      next_st;
    logic [AW:0] used;

    assign used      = st.wr - st.rd;
    assign in_ready  = (used != (AW+1)'(DEPTH));
    assign out_valid = (st.wr != st.rd);
    assign out_data  = st.mem[st.rd[AW-1:0]];
    assign level     = ($clog2(DEPTH+1))'(used);

    always_comb begin
        next_st = st;
        if (flush) begin
            next_st.wr = '0;
            next_st.rd = '0;
        end else begin
            if (in_valid && in_ready) begin
                next_st.mem[st.wr[AW-1:0]] = in_data;
                next_st.wr                 = st.wr + 1'b1;
            end
            if (out_valid && out_ready) begin
                next_st.rd = st.rd + 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

//--- verification/vtc_model.sv
// Behavioural video timing controller driving the pixel word bus
`timescale 1ns/1ps
module vtc_model (
    input  wire logic                           pclk,
    output logic                                pixel_clock,
    output logic      [col_drv_pkg::WORD_W-1:0] pixel_data,
    output logic                                sequence_start,
    output logic                                transfer_strobe
);
    initial begin
        pixel_clock = 1'b0;
        pixel_data = 10'h000;
        sequence_start = 1'b0;
        transfer_strobe = 1'b0;
    end
    // word per edge, both edges used
    // Data moves mid-phase so it is stable 4 pclk around each edge
    task automatic edge_word(input logic [9:0] w);
        repeat (4) @(posedge pclk);
        pixel_data <= w;
        repeat (4) @(posedge pclk);
        pixel_clock <= ~pixel_clock;
    endtask
    task automatic pulse_start();
        @(posedge pclk);
        sequence_start <= 1'b1;
        repeat (4) @(posedge pclk);
        sequence_start <= 1'b0;
    endtask
    task automatic set_lines(input logic st, input logic xf);
        @(posedge pclk);
        sequence_start <= st;
        transfer_strobe <= xf;
        repeat (3) @(posedge pclk);
    endtask
endmodule

//--- verification/column_driver_load_sequencer_tb.sv
// Self-checking bench for the column driver load sequencer
`timescale 1ns/1ps
module column_driver_load_sequencer_tb;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        standby_input = 1'b0;
    logic        edge_select = 1'b1;
    logic        load_direction = 1'b0;
    logic [2:0]  channel_address = 3'h7;
    logic [31:0] prdata, d;
    logic        pready, pslverr, e, pixel_clock, sequence_start, transfer_strobe;
    logic [9:0]  pixel_data;
    logic [9:0]  outs [6];
    logic [9:0]  exp_v [6] = '{default: 10'h000};
    int          bad_count = 0;
    int          total_checks = 0;
    // Small FIFO so the hold test can fill it
    column_driver_load_sequencer #(.FIFO_DEPTH(4)) u_column_driver_load_sequencer (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pixel_clock(pixel_clock), .pixel_data(pixel_data), .sequence_start(sequence_start),
        .transfer_strobe(transfer_strobe), .standby_input(standby_input), .edge_select(edge_select),
        .load_direction(load_direction), .channel_address(channel_address),
        .column_output_0(outs[0]), .column_output_1(outs[1]), .column_output_2(outs[2]),
        .column_output_3(outs[3]), .column_output_4(outs[4]), .column_output_5(outs[5]));
    vtc_model u_vtc_model (.pclk(pclk), .pixel_clock(pixel_clock), .pixel_data(pixel_data),
        .sequence_start(sequence_start), .transfer_strobe(transfer_strobe));
    always #25 pclk = ~pclk;
    // ****
    // Shared tasks
    // ****
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        total_checks++;
        if (got !== want) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h want=%h", $time, got, want);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a stuck access
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic ew(input logic [9:0] w);
        u_vtc_model.edge_word(w);
    endtask
    task automatic chk_outs();
        for (int k = 0; k < 6; k++) begin
            chk({22'h0, outs[k]}, {22'h0, exp_v[k]});
            apb(1'b0, col_drv_pkg::CH_OFS + 8'(4 * k), 32'h0);
            chk(d, {22'h0, exp_v[k]});
        end
    endtask
    // Transfer pulse, one rising edge, then the falling edge that applies it
    task automatic xfer(input logic st, input logic [9:0] nv [6]);
        u_vtc_model.set_lines(st, 1'b1);
        u_vtc_model.set_lines(st, 1'b0);
        ew(10'h3ff);
        repeat (6) @(posedge pclk);
        chk_outs();
        ew(10'h3fe);
        repeat (6) @(posedge pclk);
        exp_v = nv;
        chk_outs();
    endtask
    // ****
    // Scenarios
    // ****
    task automatic seq_run(input logic es, input logic dir, input logic [9:0] base);
        logic [9:0] nv [6];
        nv = exp_v;
        edge_select <= es;
        load_direction <= dir;
        channel_address <= 3'h7;
        if (pixel_clock === 1'b1) ew(10'h3ff);
        u_vtc_model.pulse_start();
        // Fourteen edges: the seventh capture edge must be ignored
        for (int i = 0; i < 14; i++) ew(base + 10'(i));
        for (int i = 0; i < 6; i++) nv[dir ? 5 - i : i] = base + 10'(2 * i) + 10'(!es);
        repeat (6) @(posedge pclk);
        chk_outs();
        xfer(1'b0, nv);
        $display("sequenced es=%0d dir=%0d done", es, dir);
    endtask
    task automatic direct_run();
        logic [9:0] nv [6];
        channel_address <= 3'h0;
        if (pixel_clock === 1'b1) ew(10'h3ff);
        u_vtc_model.set_lines(1'b1, 1'b1);
        for (int a = 0; a < 6; a++) begin
            channel_address <= 3'(a);
            ew(10'h155);
            ew(10'h040 + 10'(a));
            repeat (6) @(posedge pclk);
            exp_v[a] = 10'h040 + 10'(a);
            chk({22'h0, outs[a]}, {22'h0, exp_v[a]});
        end
        u_vtc_model.set_lines(1'b1, 1'b0);
        channel_address <= 3'h2;
        ew(10'h155);
        ew(10'h2aa);
        repeat (6) @(posedge pclk);
        chk_outs();
        nv = exp_v;
        nv[2] = 10'h2aa;
        // Start stays high, so falls keep loading; park on the unused address
        channel_address <= 3'h6;
        xfer(1'b1, nv);
        $display("direct and addressed done");
    endtask
    task automatic fifo_run();
        logic [9:0] nv [6];
        nv = exp_v;
        apb(1'b1, col_drv_pkg::CTRL_OFS, 32'h1);
        u_vtc_model.set_lines(1'b0, 1'b0);
        edge_select <= 1'b1;
        load_direction <= 1'b0;
        channel_address <= 3'h7;
        if (pixel_clock === 1'b1) ew(10'h3ff);
        u_vtc_model.pulse_start();
        for (int i = 0; i < 12; i++) ew(10'h100 + 10'(i));
        apb(1'b0, col_drv_pkg::STATUS_OFS, 32'h0);
        chk(d & 32'h3ff0, 32'h0000_0450);
        apb(1'b1, col_drv_pkg::STATUS_OFS, 32'h10);
        apb(1'b1, col_drv_pkg::CTRL_OFS, 32'h0);
        repeat (8) @(posedge pclk);
        apb(1'b0, col_drv_pkg::STATUS_OFS, 32'h0);
        chk(d & 32'h3ff0, 32'h0000_0020);
        for (int i = 0; i < 4; i++) nv[i] = 10'h100 + 10'(2 * i);
        xfer(1'b0, nv);
        $display("buffer fill and drain done");
    endtask
    task automatic standby_run();
        standby_input <= 1'b1;
        repeat (6) @(posedge pclk);
        exp_v = '{default: 10'h000};
        chk_outs();
        apb(1'b0, col_drv_pkg::STATUS_OFS, 32'h0);
        chk(d & 32'h80, 32'h80);
        standby_input <= 1'b0;
        $display("standby done");
    endtask
    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        wrap_up();
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        apb(1'b0, col_drv_pkg::STATUS_OFS, 32'h0);
        chk(d, 32'h0000_0020);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, e}, 32'h1);
        chk_outs();
        $display("reset and map done");
        seq_run(1'b1, 1'b0, 10'h000);
        seq_run(1'b1, 1'b1, 10'h200);
        seq_run(1'b0, 1'b0, 10'h010);
        seq_run(1'b0, 1'b1, 10'h300);
        direct_run();
        fifo_run();
        standby_run();
        wrap_up();
    end
endmodule
